// ---- rsc_brownout_filter.sv ----
// low supply duration filter counting sub-clock edges
`timescale 1ns/1ps
`default_nettype none
module rsc_brownout_filter #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // qualifying inputs, already synchronised
  input wire logic en,
  input wire logic low,
  input wire logic sub_lvl,
  input wire logic [1:0] width_sel,
  // one-cycle pulse once the low state is long enough
  output logic trip
);
  typedef struct packed {
    logic sub_prev;
    logic [CNT_W-1:0] cnt;
    logic trip;
  } rsc_filt_state_type;

  rsc_filt_state_type s_q;
  rsc_filt_state_type s_d;
  logic [CNT_W-1:0] lim;
  logic tick;

  default clocking filt_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // count rising sub-clock edges while low; any recovery restarts
  always_comb begin
    s_d = s_q;
    unique case (width_sel)
      2'h0: lim = CNT_W'(rsc_pkg::TICKS_SEL0);
      2'h1: lim = CNT_W'(rsc_pkg::TICKS_SEL1);
      2'h2: lim = CNT_W'(rsc_pkg::TICKS_SEL2);
      2'h3: lim = CNT_W'(rsc_pkg::TICKS_SEL3);
    endcase
    tick = sub_lvl && !s_q.sub_prev;
    s_d.sub_prev = sub_lvl;
    s_d.trip = 1'h0;
    if (!en || !low) begin
      s_d.cnt = '0;
    end else if (s_q.cnt > lim - CNT_W'(1)) begin
      // width cut mid-count: low is long enough, trip on the next tick
      s_d.cnt = lim - CNT_W'(1);
    end else if (tick && s_q.cnt < lim) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
      s_d.trip = (s_q.cnt == lim - CNT_W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{sub_prev: 1'h0, cnt: '0, trip: 1'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign trip = s_q.trip;

  a_dip_filter: assert property (
    s_q.trip |-> ($past(s_q.cnt) == $past(lim) - CNT_W'(1)) && $past(low)
  ) else $error("trip without full low width");
  a_width_limit: assert property (
    (width_sel == 2'h0 && $stable(width_sel)) |-> s_q.cnt <= CNT_W'(8)
  ) else $error("filter count passed select limit");
endmodule
`default_nettype wire

// ---- rsc_far_side.sv ----
// far side model: reset pin circuit and supply monitor
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
  // pacing clock
  input wire logic clk,
  // requests from the bench
  input wire logic press,
  input wire logic dip,
  // pin, comparator and sub-clock
  output logic pin_n,
  output logic supply_low,
  output var logic sub_clk
);
  logic [1:0] div_q = 2'h0;
  // pull-up brings the pin high once released
  assign pin_n = !press;
  // comparator output follows the dip directly
  assign supply_low = dip;
  // sub-clock runs free, well under half the system rate
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      sub_clk <= !sub_clk;
    end
  end
  initial sub_clk = 1'b0;
endmodule
`default_nettype wire

// ---- rsc_pkg.sv ----
// package: constants and types of the reset source controller
`default_nettype none
package rsc_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_PIN_SEL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_WIDTH = 8'h0C;
  // reset pin select codes
  localparam logic [7:0] PIN_CODE_IO = 8'h55;
  localparam logic [7:0] PIN_CODE_RES = 8'hAA;
  localparam logic [7:0] PIN_SEL_POR = 8'h55;
  // low voltage threshold codes
  localparam logic [7:0] THR_CODE_1V7 = 8'h66;
  localparam logic [7:0] THR_CODE_1V9 = 8'h55;
  localparam logic [7:0] THR_CODE_2V55 = 8'h33;
  localparam logic [7:0] THR_CODE_3V15 = 8'h99;
  localparam logic [7:0] THR_CODE_3V8 = 8'hAA;
  localparam logic [7:0] THR_CODE_OFF = 8'hF0;
  localparam logic [7:0] THRESH_POR = 8'h66;
  // level index presented to the supply monitor
  localparam logic [2:0] LVL_1V7 = 3'h0;
  localparam logic [2:0] LVL_1V9 = 3'h1;
  localparam logic [2:0] LVL_2V55 = 3'h2;
  localparam logic [2:0] LVL_3V15 = 3'h3;
  localparam logic [2:0] LVL_3V8 = 3'h4;
  localparam logic [2:0] LVL_OFF = 3'h5;
  localparam logic [2:0] LVL_BAD = 3'h7;
  // minimum low width select, in sub-clock rising edges
  localparam logic [1:0] WIDTH_POR = 2'h1;
  localparam logic [7:0] TICKS_SEL0 = 8'h08;
  localparam logic [7:0] TICKS_SEL1 = 8'h20;
  localparam logic [7:0] TICKS_SEL2 = 8'h40;
  localparam logic [7:0] TICKS_SEL3 = 8'h80;
  // flag bit positions and reset value
  localparam int FLG_PIN = 3;
  localparam int FLG_BROWN = 2;
  localparam int FLG_THR = 1;
  localparam int FLG_WDT = 0;
  localparam logic [3:0] FLAGS_POR = 4'h0;
  // timing: times in ns, counts in SYS_CLK cycles rounded up
  localparam int CLK_MHZ = 100;
  localparam int T_FAULT_NS = 2000;
  localparam int T_RELEASE_NS = 1000;
  localparam int FAULT_RAW = (T_FAULT_NS * CLK_MHZ + 999) / 1000;
  localparam int RELEASE_RAW = (T_RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int FAULT_CYC = (FAULT_RAW < 1) ? 1 : FAULT_RAW;
  localparam int RELEASE_CYC = (RELEASE_RAW < 1) ? 1 : RELEASE_RAW;
  // reset sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} rsc_seq_type;
endpackage
`default_nettype wire

// ---- rsc_reset_ctrl.sv ----
// reset source controller: pin reset, brownout, guarded register faults
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl #(
  parameter int FAULT_CYCLES = rsc_pkg::FAULT_CYC,
  parameter int RELEASE_CYCLES = rsc_pkg::RELEASE_CYC
) (
  // clock and power-on reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pin and supply monitor, asynchronous
  input wire logic RESET_PIN_N,
  input wire logic SUPPLY_LOW,
  input wire logic SUB_CLK,
  // power mode and watchdog, same clock
  input wire logic SLEEP_IDLE,
  input wire logic WDT_CTRL_FAULT,
  input wire logic WDT_WARM_RESET,
  // reset and routing outputs
  output logic CPU_RESET,
  output logic PORT_PRESET,
  output logic PIN_RESET_ROLE,
  output logic BROWNOUT_MONITOR_EN,
  output logic [2:0] THRESHOLD_LEVEL
);
  typedef struct packed {
    rsc_pkg::rsc_seq_type st;
    logic [15:0] cnt;
    logic hold_pin;
    logic por;
    logic warm;
    logic [7:0] pin_sel;
    logic [7:0] thresh;
    logic [1:0] width;
    logic [3:0] flags;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cpu_reset;
    logic port_preset;
    logic pin_role;
    logic mon_en;
    logic [2:0] level;
  } rsc_ctl_state_type;

  localparam rsc_ctl_state_type POR_STATE = '{
    st: rsc_pkg::ST_DELAY,
    cnt: 16'h0000,
    hold_pin: 1'h0,
    por: 1'h1,
    warm: 1'h0,
    pin_sel: rsc_pkg::PIN_SEL_POR,
    thresh: rsc_pkg::THRESH_POR,
    width: rsc_pkg::WIDTH_POR,
    flags: rsc_pkg::FLAGS_POR,
    pready: 1'h0,
    pslverr: 1'h0,
    prdata: 32'h0000_0000,
    cpu_reset: 1'h1,
    port_preset: 1'h1,
    pin_role: 1'h0,
    mon_en: 1'h0,
    level: rsc_pkg::LVL_1V7
  };

  rsc_ctl_state_type s_q;
  rsc_ctl_state_type s_d;
  logic [2:0] sync_lvl;
  logic pin_n_s;
  logic low_s;
  logic sub_s;
  logic trip;
  logic [2:0] lvl;
  logic pin_bad;
  logic thr_bad;
  logic bus_first;
  logic bus_wr;
  logic go_wdt;
  logic go_fault;
  logic go_brown;
  logic go_pin;
  logic go_warm;
  logic go_any;

  default clocking main_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  // threshold code to monitor level, anything else is a fault
  function automatic logic [2:0] thr_level(input logic [7:0] code);
    logic [2:0] r;
    r = rsc_pkg::LVL_BAD;
    case (code)
      rsc_pkg::THR_CODE_1V7: r = rsc_pkg::LVL_1V7;
      rsc_pkg::THR_CODE_1V9: r = rsc_pkg::LVL_1V9;
      rsc_pkg::THR_CODE_2V55: r = rsc_pkg::LVL_2V55;
      rsc_pkg::THR_CODE_3V15: r = rsc_pkg::LVL_3V15;
      rsc_pkg::THR_CODE_3V8: r = rsc_pkg::LVL_3V8;
      rsc_pkg::THR_CODE_OFF: r = rsc_pkg::LVL_OFF;
      default: r = rsc_pkg::LVL_BAD;
    endcase
    return r;
  endfunction

  // pin, supply and sub-clock cross in through two flops each
  rsc_sync2 #(
    .WIDTH(3),
    .RST_VAL(3'h1)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .async_in({SUB_CLK, SUPPLY_LOW, RESET_PIN_N}),
    .sync_out(sync_lvl)
  );
  assign pin_n_s = sync_lvl[0];
  assign low_s = sync_lvl[1];
  assign sub_s = sync_lvl[2];

  // filter only runs while the cpu runs and the monitor is on
  rsc_brownout_filter #(
    .CNT_W(8)
  ) u_filter (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .en(s_q.mon_en && (s_q.st == rsc_pkg::ST_RUN)),
    .low(low_s),
    .sub_lvl(sub_s),
    .width_sel(s_q.width),
    .trip(trip)
  );

  // bus, sequencer and registered outputs
  always_comb begin
    s_d = s_q;
    lvl = thr_level(s_q.thresh);
    pin_bad = (s_q.pin_sel != rsc_pkg::PIN_CODE_IO) &&
              (s_q.pin_sel != rsc_pkg::PIN_CODE_RES);
    thr_bad = (lvl == rsc_pkg::LVL_BAD);
    bus_first = PSEL && PENABLE && !s_q.pready;
    bus_wr = PSEL && PENABLE && PWRITE && s_q.pready;
    go_wdt = 1'h0;
    go_fault = 1'h0;
    go_brown = 1'h0;
    go_pin = 1'h0;
    go_warm = 1'h0;
    // one wait state: data and error sampled on the first access cycle
    s_d.pready = bus_first;
    s_d.pslverr = 1'h0;
    if (bus_first) begin
      s_d.prdata = 32'h0000_0000;
      if (PADDR == rsc_pkg::ADDR_PIN_SEL) begin
        s_d.prdata[7:0] = s_q.pin_sel;
      end else if (PADDR == rsc_pkg::ADDR_FLAGS) begin
        s_d.prdata[3:0] = s_q.flags;
      end else if (PADDR == rsc_pkg::ADDR_THRESH) begin
        s_d.prdata[7:0] = s_q.thresh;
      end else if (PADDR == rsc_pkg::ADDR_WIDTH) begin
        s_d.prdata[1:0] = s_q.width;
      end else begin
        s_d.pslverr = 1'h1;
      end
    end
    // writes land on the edge that completes the access
    if (bus_wr) begin
      if (PADDR == rsc_pkg::ADDR_PIN_SEL) begin
        s_d.pin_sel = PWDATA[7:0];
      end else if (PADDR == rsc_pkg::ADDR_FLAGS) begin
        s_d.flags = s_q.flags & PWDATA[3:0];
      end else if (PADDR == rsc_pkg::ADDR_THRESH) begin
        s_d.thresh = PWDATA[7:0];
      end else if (PADDR == rsc_pkg::ADDR_WIDTH) begin
        s_d.width = PWDATA[1:0];
      end
    end
    // sequencer; the counter times faults in run, release in delay
    unique case (s_q.st)
      rsc_pkg::ST_RUN: begin
        s_d.cnt = (pin_bad || thr_bad) ? s_q.cnt + 16'h0001 : 16'h0000;
        if (WDT_CTRL_FAULT) begin
          go_wdt = 1'h1;
        end else if ((pin_bad || thr_bad) &&
                     s_q.cnt == 16'(FAULT_CYCLES - 1)) begin
          go_fault = 1'h1;
        end else if (trip) begin
          go_brown = 1'h1;
        end else if (s_q.pin_role && !pin_n_s) begin
          go_pin = 1'h1;
        end else if (WDT_WARM_RESET) begin
          go_warm = 1'h1;
        end
      end
      rsc_pkg::ST_HOLD: begin
        // wait until the holding cause has gone away
        if (s_q.hold_pin ? pin_n_s : !low_s) begin
          s_d.st = rsc_pkg::ST_DELAY;
          s_d.cnt = 16'h0000;
        end
      end
      rsc_pkg::ST_DELAY: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'(RELEASE_CYCLES - 1)) begin
          s_d.st = rsc_pkg::ST_RUN;
          s_d.cnt = 16'h0000;
          s_d.por = 1'h0;
          s_d.warm = 1'h0;
        end
      end
      default: begin
        s_d.st = rsc_pkg::ST_DELAY;
        s_d.cnt = 16'h0000;
      end
    endcase
    go_any = go_wdt || go_fault || go_brown || go_pin || go_warm;
    // reset entry; reloads override a write in the same cycle
    if (go_any) begin
      s_d.st = (go_brown || go_pin) ? rsc_pkg::ST_HOLD : rsc_pkg::ST_DELAY;
      s_d.cnt = 16'h0000;
      s_d.hold_pin = go_pin;
      s_d.warm = go_warm;
      if (!go_warm) begin
        s_d.pin_sel = rsc_pkg::PIN_SEL_POR;
      end
      if (!go_warm && !go_brown) begin
        s_d.thresh = rsc_pkg::THRESH_POR;
      end
    end
    // hardware sets come after the software clear, so sets win
    if (go_wdt) begin
      s_d.flags[rsc_pkg::FLG_WDT] = 1'h1;
    end
    if (go_fault && pin_bad) begin
      s_d.flags[rsc_pkg::FLG_PIN] = 1'h1;
    end
    if (go_fault && thr_bad) begin
      s_d.flags[rsc_pkg::FLG_THR] = 1'h1;
    end
    if (go_brown) begin
      s_d.flags[rsc_pkg::FLG_BROWN] = 1'h1;
    end
    // outputs come from flops, computed from the next state
    s_d.cpu_reset = (s_d.st != rsc_pkg::ST_RUN);
    s_d.port_preset = s_d.por;
    // a pin reset keeps the pin in its reset role while held, until the pin is released
    s_d.pin_role = (s_d.pin_sel == rsc_pkg::PIN_CODE_RES) ||
                   ((s_d.st == rsc_pkg::ST_HOLD) && s_d.hold_pin);
    s_d.level = thr_level(s_d.thresh);
    s_d.mon_en = (s_d.level <= rsc_pkg::LVL_3V8) && !SLEEP_IDLE;
  end

  // power-on reset loads every register with its power-on value
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s_q <= POR_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign CPU_RESET = s_q.cpu_reset;
  assign PORT_PRESET = s_q.port_preset;
  assign PIN_RESET_ROLE = s_q.pin_role;
  assign BROWNOUT_MONITOR_EN = s_q.mon_en;
  assign THRESHOLD_LEVEL = s_q.level;

  a_pin_role_set: assert property (
    (bus_wr && PADDR == rsc_pkg::ADDR_PIN_SEL &&
     PWDATA[7:0] == rsc_pkg::PIN_CODE_RES && !go_any) |=> PIN_RESET_ROLE
  ) else $error("reset role not taken after code write");
  a_pin_fault_reset: assert property (
    (s_q.st == rsc_pkg::ST_RUN && pin_bad && !WDT_CTRL_FAULT &&
     s_q.cnt == 16'(FAULT_CYCLES - 1)) |=>
    (s_q.flags[rsc_pkg::FLG_PIN] && CPU_RESET && s_q.st == rsc_pkg::ST_DELAY)
  ) else $error("pin select fault did not reset");
  a_fault_delay_len: assert property (
    $rose(s_q.flags[rsc_pkg::FLG_THR]) |->
    $past(s_q.cnt) == 16'(FAULT_CYCLES - 1)
  ) else $error("threshold fault reset before delay");
  a_pin_reload: assert property (
    ($rose(CPU_RESET) && !s_q.warm) |-> s_q.pin_sel == rsc_pkg::PIN_SEL_POR
  ) else $error("pin select not reloaded on reset");
  a_thresh_keep: assert property (
    go_brown |=> (s_q.thresh == $past(s_q.thresh)) && CPU_RESET
  ) else $error("threshold changed by brownout reset");
  a_thresh_reload: assert property (
    (go_fault && thr_bad) |=> s_q.thresh == rsc_pkg::THRESH_POR
  ) else $error("threshold not reloaded after fault");
  a_flag_set_wins: assert property (
    (go_fault && pin_bad && bus_wr && PADDR == rsc_pkg::ADDR_FLAGS) |=>
    s_q.flags[rsc_pkg::FLG_PIN]
  ) else $error("flag set lost to clear");
  a_flags_upper: assert property (
    (PREADY && PADDR == rsc_pkg::ADDR_FLAGS && !PSLVERR) |->
    PRDATA[7:4] == 4'h0
  ) else $error("upper flag bits not zero");
  a_sleep_off: assert property (
    SLEEP_IDLE |=> !BROWNOUT_MONITOR_EN
  ) else $error("monitor on during sleep");
  a_disable_code: assert property (
    s_q.thresh == rsc_pkg::THR_CODE_OFF |-> !BROWNOUT_MONITOR_EN
  ) else $error("monitor on with disable code");
  a_level_map: assert property (
    s_q.thresh == rsc_pkg::THR_CODE_2V55 |->
    THRESHOLD_LEVEL == rsc_pkg::LVL_2V55
  ) else $error("threshold level decode wrong");
  a_pin_hold: assert property (
    (s_q.st == rsc_pkg::ST_RUN && s_q.pin_role && !pin_n_s) |=> CPU_RESET
  ) else $error("pin low did not reset");
  a_release_delay: assert property (
    $fell(CPU_RESET) |-> $past(s_q.cnt) == 16'(RELEASE_CYCLES - 1)
  ) else $error("reset released early");
endmodule
`default_nettype wire

// ---- rsc_sync2.sv ----
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rsc_sync_state_type;

  rsc_sync_state_type s_q;
  rsc_sync_state_type s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule
`default_nettype wire

// ---- tb_mcu_reset_source_control.sv ----
// testbench of the reset source controller
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_reset_source_control;
  // short counts keep the run brief
  localparam int FLT = 20;
  localparam int RLS = 10;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_n, supply_low, sub_clk;
  logic sleep_idle = 1'b0;
  logic wdt_fault = 1'b0;
  logic wdt_warm = 1'b0;
  logic press = 1'b0;
  logic dip = 1'b0;
  logic cpu_reset, port_preset, pin_role, mon_en;
  logic [2:0] thr_level;
  logic [31:0] rdv;
  logic e;
  logic [7:0] code;
  logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  always #5 sys_clk = ~sys_clk;

  rsc_reset_ctrl #(.FAULT_CYCLES(FLT), .RELEASE_CYCLES(RLS)) dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RESET_PIN_N(pin_n),
    .SUPPLY_LOW(supply_low), .SUB_CLK(sub_clk), .SLEEP_IDLE(sleep_idle),
    .WDT_CTRL_FAULT(wdt_fault), .WDT_WARM_RESET(wdt_warm),
    .CPU_RESET(cpu_reset), .PORT_PRESET(port_preset),
    .PIN_RESET_ROLE(pin_role), .BROWNOUT_MONITOR_EN(mon_en),
    .THRESHOLD_LEVEL(thr_level));

  rsc_far_side far (.clk(sys_clk), .press(press), .dip(dip),
    .pin_n(pin_n), .supply_low(supply_low), .sub_clk(sub_clk));

  // expected monitor level for a threshold code
  function automatic logic [2:0] lvl_of(input logic [7:0] c);
    case (c)
      8'h66: return 3'h0;
      8'h55: return 3'h1;
      8'h33: return 3'h2;
      8'h99: return 3'h3;
      8'hAA: return 3'h4;
      8'hF0: return 3'h5;
      default: return 3'h7;
    endcase
  endfunction

  task automatic results;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdv, x, "register read");
  endtask

  task automatic rise_wait;
    n = 0;
    while (cpu_reset !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk(cpu_reset, 1'b1, "cpu reset raised");
  endtask

  // counts cycles of reset left, bounded by the global timeout
  task automatic fall_wait;
    n = 0;
    while (cpu_reset !== 1'b0) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // hang guard well above the planned run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  initial begin
    void'($urandom(53));
    repeat (2) @(posedge sys_clk);
    chk(cpu_reset, 1'b1, "power-on hold");
    chk(port_preset, 1'b1, "port preset");
    reset_n <= 1'b1;
    fall_wait();
    chk(n >= RLS, 1'b1, "start delay");
    rd(rsc_pkg::ADDR_PIN_SEL, 32'h55);
    rd(rsc_pkg::ADDR_THRESH, 32'h66);
    rd(rsc_pkg::ADDR_WIDTH, 32'h1);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    rd(rsc_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1'b1, "unmapped error");
    // every threshold code and its level
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, rsc_pkg::ADDR_THRESH, {24'h0, codes[i]});
      repeat (2) @(posedge sys_clk);
      chk(thr_level, lvl_of(codes[i]), "level");
      chk(mon_en, codes[i] != 8'hF0, "monitor enable");
    end
    apb(1'b1, rsc_pkg::ADDR_THRESH, 32'h66);
    sleep_idle <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(mon_en, 1'b0, "sleep disables");
    sleep_idle <= 1'b0;
    // pin reset through the external pin role
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, 32'hAA);
    repeat (2) @(posedge sys_clk);
    chk(pin_role, 1'b1, "pin role");
    press <= 1'b1;
    rise_wait();
    chk(port_preset, 1'b0, "no port preset");
    repeat (5) @(posedge sys_clk);
    press <= 1'b0;
    fall_wait();
    chk(n >= RLS, 1'b1, "pin release delay");
    rd(rsc_pkg::ADDR_PIN_SEL, 32'h55);
    chk(pin_role, 1'b0, "io role back");
    // invalid pin code, first corrected in time, then left
    do code = 8'($urandom); while (code == 8'h55 || code == 8'hAA);
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, {24'h0, code});
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, 32'h55);
    repeat (FLT + 5) @(posedge sys_clk);
    chk(cpu_reset, 1'b0, "corrected code");
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, {24'h0, code});
    repeat (FLT - 6) @(posedge sys_clk);
    chk(cpu_reset, 1'b0, "fault delay");
    // flag clear lands on the very edge of the fault reset: set wins
    repeat (2) @(posedge sys_clk);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'h0);
    rise_wait();
    fall_wait();
    rd(rsc_pkg::ADDR_FLAGS, 32'h8);
    rd(rsc_pkg::ADDR_PIN_SEL, 32'h55);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'hF);
    rd(rsc_pkg::ADDR_FLAGS, 32'h8);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'h0);
    rd(rsc_pkg::ADDR_FLAGS, 32'h0);
    // undefined threshold code
    do code = 8'($urandom); while (lvl_of(code) != 3'h7);
    apb(1'b1, rsc_pkg::ADDR_THRESH, {24'h0, code});
    rise_wait();
    fall_wait();
    rd(rsc_pkg::ADDR_FLAGS, 32'h2);
    rd(rsc_pkg::ADDR_THRESH, 32'h66);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'h0);
    // brownout: short dips ignored, long dip resets
    apb(1'b1, rsc_pkg::ADDR_THRESH, 32'h33);
    apb(1'b1, rsc_pkg::ADDR_WIDTH, 32'h1);
    dip <= 1'b1;
    repeat (150) @(posedge sys_clk);
    dip <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(cpu_reset, 1'b0, "width one dip");
    apb(1'b1, rsc_pkg::ADDR_WIDTH, 32'h0);
    dip <= 1'b1;
    repeat (40) @(posedge sys_clk);
    dip <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(cpu_reset, 1'b0, "short dip");
    dip <= 1'b1;
    rise_wait();
    dip <= 1'b0;
    fall_wait();
    rd(rsc_pkg::ADDR_FLAGS, 32'h4);
    rd(rsc_pkg::ADDR_THRESH, 32'h33);
    apb(1'b1, rsc_pkg::ADDR_FLAGS, 32'h0);
    // warm reset keeps pin select, watchdog fault sets its flag
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, 32'hAA);
    wdt_warm <= 1'b1;
    @(posedge sys_clk);
    wdt_warm <= 1'b0;
    rise_wait();
    fall_wait();
    rd(rsc_pkg::ADDR_PIN_SEL, 32'hAA);
    apb(1'b1, rsc_pkg::ADDR_PIN_SEL, 32'h55);
    wdt_fault <= 1'b1;
    @(posedge sys_clk);
    wdt_fault <= 1'b0;
    rise_wait();
    fall_wait();
    rd(rsc_pkg::ADDR_FLAGS, 32'h1);
    results();
  end
endmodule
`default_nettype wire
